// ---- hw/cpfc_pkg.sv ----
// shared constants of the pixel format converter
// assumes an avalon-mm master with byte addresses and 32-bit data
package cpfc_pkg;
    // ----------------------------------------
    // register map, byte offsets
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_WB      = 4'h4;
    localparam logic [3:0] REG_SAT     = 4'h8;
    localparam logic [3:0] REG_STATUS  = 4'hC;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_COMP    = 3;
    localparam int CTRL_WB_EN   = 4;
    localparam int CTRL_CA_EN   = 5;
    localparam int CTRL_GAM_EN  = 6;
    localparam int WB_R_LSB     = 0;
    localparam int WB_G_LSB     = 8;
    localparam int WB_B_LSB     = 16;
    localparam int STAT_LVL_LSB = 16;
    localparam logic [6:0]  CTRL_RST = 7'h00;
    localparam logic [23:0] WB_RST   = 24'h10_1010;
    localparam logic [7:0]  SAT_RST  = 8'h10;
    // ----------------------------------------
    // output formats
    // ----------------------------------------
    typedef enum logic [2:0] {
        FMT_RAW8   = 3'b000,
        FMT_RAW12  = 3'b001,
        FMT_YUV_UY = 3'b010,
        FMT_YUV_YU = 3'b011,
        FMT_MONO8  = 3'b100
    } cpfc_fmt_type;
    // ----------------------------------------
    // matrix coefficients, scaled by 256
    // ----------------------------------------
    localparam int K_YR = 77;
    localparam int K_YG = 151;
    localparam int K_YB = 28;
    localparam int K_UR = -44;
    localparam int K_UG = -84;
    localparam int K_UB = 128;
    localparam int K_VR = 128;
    localparam int K_VG = -105;
    localparam int K_VB = -23;
    localparam int K_RV = 359;
    localparam int K_GU = -88;
    localparam int K_GV = -183;
    localparam int K_BU = 454;
    localparam int C_OFS = 128;
endpackage : cpfc_pkg

// ---- hw/cpfc_top.sv ----
// pixel format converter: raw, packed 4:2:2 or luma-only output
// assumes a sensor stream with start-of-frame and end-of-line marks
//
// Notes on behaviour
// - raw12 passes samples through untouched, raw8 keeps their upper 8 bits
// - raw word holds one 8/12-bit colour sample
// - two packed 4:2:2 orders, one luma-first
// - demosaic to full rgb before yuv conversion
// - u from -0.17r -0.33g +0.50b
// - mono format sends luma of demosaiced pixel
// - complementary sensor bins vertical pixel pairs
// - both fields processed the same way
// - binned four-colour data first becomes yuv
// - matrix turns that yuv into rgb
// - white balance, adjust, gamma, in order
// - corrected rgb back to yuv, then sent
// - complementary mono sends luma only
// - blue-green phase drives demosaic sites
`timescale 1ns/1ps
`default_nettype none

module cpfc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       in_valid,
    input  wire logic [W-1:0]               in_data,
    output logic                            in_ready,
    output logic                            out_valid,
    output logic [W-1:0]                    out_data,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    logic         push;
    logic         pop;

    assign level     = wp_q - rp_q;
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (wp_q != rp_q);
    assign out_data  = mem[rp_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule : cpfc_fifo

module cpfc_top
    import cpfc_pkg::*;
#(
    parameter int MAX_W = 2048,
    parameter int DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  av_address,
    input  wire logic        av_read,
    input  wire logic        av_write,
    input  wire logic [31:0] av_writedata,
    input  wire logic [3:0]  av_byteenable,
    output logic [31:0]      av_readdata,
    output logic             av_waitrequest,
    input  wire logic        in_valid,
    input  wire logic [11:0] in_data,
    input  wire logic        in_sof,
    input  wire logic        in_eol,
    output logic             in_ready,
    output logic             out_valid,
    output logic [15:0]      out_data,
    input  wire logic        out_ready
);
    localparam int XW = $clog2(MAX_W);
    localparam int LW = $clog2(DEPTH) + 1;

    typedef struct packed {
        logic [XW-1:0] x;
        logic          row;
        logic          bline;
        logic [11:0]   left;
        logic [11:0]   upleft;
        logic [7:0]    held_v;
        logic [7:0]    cmy_u;
        logic [7:0]    cmy_v;
        logic          v;
        logic [15:0]   d;
        logic          rdy;
        logic          ov;
        logic [15:0]   od;
        logic          waitreq;
        logic [31:0]   rdata;
        logic [6:0]    ctrl;
        logic [23:0]   wb;
        logic [7:0]    sat;
        logic [15:0]   cnt;
    } cpfc_state_type;

    localparam cpfc_state_type ST_RST = '{
        ctrl: CTRL_RST, wb: WB_RST, sat: SAT_RST, waitreq: 1'b1, default: '0};

    cpfc_state_type s_q;
    cpfc_state_type s_d;
    logic [11:0]    line_mem [MAX_W];
    logic           f_ready;
    logic           f_ov;
    logic [15:0]    f_od;
    logic [LW-1:0]  f_lvl;
    logic           f_pop;

    // ----------------------------------------
    // arithmetic helpers
    // ----------------------------------------
    function automatic logic [7:0] sat8(input int v);
        if (v < 0) begin
            return 8'h00;
        end else if (v > 255) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction : sat8

    function automatic logic [23:0] rgb2yuv(input int r, input int g, input int b);
        logic [7:0] y;
        logic [7:0] u;
        logic [7:0] v;
        y = sat8((K_YR * r + K_YG * g + K_YB * b + C_OFS) >>> 8);
        u = sat8(((K_UR * r + K_UG * g + K_UB * b + C_OFS) >>> 8) + C_OFS);
        v = sat8(((K_VR * r + K_VG * g + K_VB * b + C_OFS) >>> 8) + C_OFS);
        return {y, u, v};
    endfunction : rgb2yuv

    // knee curve: steep in the shadows, flat in the highlights
    function automatic int gam(input int x);
        if (x < 64) begin
            return 2 * x;
        end
        return 128 + (((x - 64) * 171) >>> 8);
    endfunction : gam

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = w[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic          acc;
        logic [XW-1:0] ex;
        logic          erow;
        logic          comp;
        logic [11:0]   e [4];
        logic [11:0]   up;
        int            r;
        int            g;
        int            b;
        int            y;
        int            u;
        int            v;
        int            b0;
        int            b1;
        int            gs;
        logic [23:0]   yuv;
        logic          emit;
        logic [15:0]   word;
        logic [31:0]   w;
        s_d  = s_q;
        acc  = in_valid && s_q.rdy;
        ex   = in_sof ? '0 : s_q.x;
        erow = in_sof ? 1'b0 : s_q.row;
        comp = s_q.ctrl[CTRL_COMP];
        up   = line_mem[ex];
        e[0] = in_data;
        e[1] = (ex == '0) ? 12'h000 : s_q.left;
        e[2] = up;
        e[3] = (ex == '0) ? 12'h000 : s_q.upleft;
        r = 0;
        g = 0;
        b = 0;
        gs = 0;
        y = 0;
        u = 0;
        v = 0;
        b0 = 0;
        b1 = 0;
        word = '0;
        w = '0;
        // sites of the 2x2 block around the pixel, blue at even row and column
        for (int i = 0; i < 4; i++) begin
            logic rp;
            logic cp;
            rp = erow ^ (i >= 2);
            cp = ex[0] ^ i[0];
            if (rp && cp) begin
                r = int'(e[i][11:4]);
            end else if (!rp && !cp) begin
                b = int'(e[i][11:4]);
            end else begin
                gs = gs + int'(e[i][11:4]);
            end
        end
        g = gs >>> 1;
        emit = 1'b1;
        if (comp) begin
            // field number is not looked at: both fields bin to the same sums
            b0 = int'(in_data) + int'(up);
            b1 = int'(e[1]) + int'(e[3]);
            y  = (b0 + b1) >>> 6;
            // chroma state moves only with accepted samples, never on idle cycles
            if (acc && s_q.bline) begin
                s_d.cmy_u = sat8(((b0 - b1) >>> 5) + C_OFS);
            end else if (acc) begin
                s_d.cmy_v = sat8(((b0 - b1) >>> 5) + C_OFS);
            end
            u = int'(s_q.cmy_u) - C_OFS;
            v = int'(s_q.cmy_v) - C_OFS;
            r = int'(sat8(y + ((K_RV * v) >>> 8)));
            g = int'(sat8(y + ((K_GU * u + K_GV * v) >>> 8)));
            b = int'(sat8(y + ((K_BU * u) >>> 8)));
            if (s_q.ctrl[CTRL_WB_EN]) begin
                r = int'(sat8((r * int'(s_q.wb[WB_R_LSB +: 8])) >>> 4));
                g = int'(sat8((g * int'(s_q.wb[WB_G_LSB +: 8])) >>> 4));
                b = int'(sat8((b * int'(s_q.wb[WB_B_LSB +: 8])) >>> 4));
            end
            if (s_q.ctrl[CTRL_CA_EN]) begin
                y = int'(rgb2yuv(r, g, b) >> 16);
                r = int'(sat8(y + (((r - y) * int'(s_q.sat)) >>> 4)));
                g = int'(sat8(y + (((g - y) * int'(s_q.sat)) >>> 4)));
                b = int'(sat8(y + (((b - y) * int'(s_q.sat)) >>> 4)));
            end
            if (s_q.ctrl[CTRL_GAM_EN]) begin
                r = gam(r);
                g = gam(g);
                b = gam(b);
            end
            // only the second line of each vertical pair yields a binned pixel
            emit = erow;
        end
        yuv = rgb2yuv(r, g, b);
        unique case (s_q.ctrl[CTRL_FMT_LSB +: 3])
            FMT_RAW12: begin
                word = {4'h0, in_data};
                emit = 1'b1;
            end
            FMT_MONO8: begin
                word = {8'h00, yuv[23:16]};
            end
            FMT_YUV_UY: begin
                word = ex[0] ? {yuv[23:16], s_q.held_v}
                             : {yuv[23:16], yuv[15:8]};
            end
            FMT_YUV_YU: begin
                word = ex[0] ? {s_q.held_v, yuv[23:16]}
                             : {yuv[15:8], yuv[23:16]};
            end
            default: begin
                word = {8'h00, in_data[11:4]};
                emit = 1'b1;
            end
        endcase
        s_d.v = acc && emit;
        if (acc) begin
            s_d.d    = word;
            s_d.left = in_data;
            s_d.upleft = up;
            s_d.x    = in_eol ? '0 : ex + 1'b1;
            s_d.row  = in_eol ? ~erow : erow;
            if (in_sof) begin
                s_d.bline = 1'b0;
            end else if (in_eol && comp && erow) begin
                s_d.bline = ~s_q.bline;
            end
            if (!ex[0]) begin
                s_d.held_v = yuv[7:0];
            end
        end
        if (s_q.v) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        // at least four free entries: one for the stage register, one for the word being accepted, one behind the registered ready, one spare
        s_d.rdy = f_ready && (f_lvl < LW'(DEPTH - 3));
        s_d.ov  = f_pop ? 1'b1 : (out_ready ? 1'b0 : s_q.ov);
        s_d.od  = f_pop ? f_od : s_q.od;
        // ----------------------------------------
        // avalon slave, one wait cycle per access
        // ----------------------------------------
        s_d.waitreq = !((av_read || av_write) && s_q.waitreq);
        if (av_read && s_q.waitreq) begin
            unique case (av_address)
                REG_CTRL:   s_d.rdata = {25'h000_0000, s_q.ctrl};
                REG_WB:     s_d.rdata = {8'h00, s_q.wb};
                REG_SAT:    s_d.rdata = {24'h00_0000, s_q.sat};
                REG_STATUS: s_d.rdata = {(16 - LW)'(0), f_lvl, s_q.cnt};
                default:    s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (av_write && !s_q.waitreq) begin
            w = be_merge({25'h000_0000, s_q.ctrl}, av_writedata, av_byteenable);
            if (av_address == REG_CTRL) begin
                s_d.ctrl = w[6:0];
            end
            w = be_merge({8'h00, s_q.wb}, av_writedata, av_byteenable);
            if (av_address == REG_WB) begin
                s_d.wb = w[23:0];
            end
            w = be_merge({24'h00_0000, s_q.sat}, av_writedata, av_byteenable);
            if (av_address == REG_SAT) begin
                s_d.sat = w[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        s_q <= srst ? ST_RST : s_d;
        if (in_valid && s_q.rdy) begin
            line_mem[in_sof ? XW'(0) : s_q.x] <= in_data;
        end
    end

    assign f_pop = f_ov && (!s_q.ov || out_ready);

    cpfc_fifo #(
        .W     (16),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (s_q.v),
        .in_data   (s_q.d),
        .in_ready  (f_ready),
        .out_valid (f_ov),
        .out_data  (f_od),
        .out_ready (!s_q.ov || out_ready),
        .level     (f_lvl)
    );

    assign in_ready       = s_q.rdy;
    assign out_valid      = s_q.ov;
    assign out_data       = s_q.od;
    assign av_readdata    = s_q.rdata;
    assign av_waitrequest = s_q.waitreq;
endmodule : cpfc_top

`default_nettype wire

// ---- tb/cpfc_top_assertions.sv ----
// port checker for the pixel format converter top
// assumes it is bound to cpfc_top and sees only its ports, one clock
`timescale 1ns/1ps
`default_nettype none
module cpfc_top_assertions
    import cpfc_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [3:0]  av_address,
    input wire logic        av_read,
    input wire logic        av_write,
    input wire logic [31:0] av_writedata,
    input wire logic [3:0]  av_byteenable,
    input wire logic [31:0] av_readdata,
    input wire logic        av_waitrequest,
    input wire logic        in_valid,
    input wire logic [11:0] in_data,
    input wire logic        in_sof,
    input wire logic        in_eol,
    input wire logic        in_ready,
    input wire logic        out_valid,
    input wire logic [15:0] out_data,
    input wire logic        out_ready
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    // shadow of the format field; words in flight across a change are judged against the new format
    logic [2:0] fmt_q;
    logic       comp_q;
    logic [7:0] pend_q;
    logic       take;
    assign take = in_valid && in_ready;
    always_ff @(posedge clk) begin
        if (srst) begin
            fmt_q  <= 3'h0;
            comp_q <= 1'b0;
            pend_q <= 8'h00;
        end else begin
            if (av_write && !av_waitrequest && av_address == REG_CTRL && av_byteenable[0]) begin
                fmt_q  <= av_writedata[2:0];
                comp_q <= av_writedata[3];
            end
            pend_q <= pend_q + 8'(take) - 8'(out_valid && out_ready);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_idle3;
        !out_valid [*3];
    endsequence
    AST_BUS_ANSWER: assert property ((av_read || av_write) && av_waitrequest |=> !av_waitrequest)
        else $error("waitrequest not low one cycle after request");
    AST_BUS_PULSE: assert property (!av_waitrequest |=> av_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_RESET_QUIET: assert property ($fell(srst) |-> !out_valid && !in_ready)
        else $error("stream outputs active right after reset");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word changed before being taken");
    AST_RAW8_WORD: assert property (out_valid && fmt_q == FMT_RAW8 |-> out_data[15:8] == 8'h00)
        else $error("raw8 word has bits above the sample");
    AST_RAW12_WORD: assert property (out_valid && fmt_q == FMT_RAW12 |-> out_data[15:12] == 4'h0)
        else $error("raw12 word has bits above the sample");
    AST_MONO_WORD: assert property (out_valid && fmt_q == FMT_MONO8 |-> out_data[15:8] == 8'h00)
        else $error("luma-only word carries more than luma");
    AST_NO_EXTRA: assert property (out_valid |-> pend_q != 8'h00)
        else $error("word sent without a sample behind it");
    AST_FIRST_WORD: assert property (take && pend_q == 8'h00 && !comp_q |-> s_idle3 ##1 out_valid)
        else $error("first word not three cycles after its sample");
endmodule : cpfc_top_assertions
`default_nettype wire

// ---- tb/cpfc_sink.sv ----
// downstream frame transmitter model: takes words, can stall
// assumes the converter's valid/ready output stream
`timescale 1ns/1ps
`default_nettype none
module cpfc_sink (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [15:0] out_data,
    output logic             out_ready
);
    logic [15:0] q[$];
    always @(posedge clk) begin
        if (srst) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                q.push_back(out_data);
            end
            out_ready <= !stall;
        end
    end
endmodule : cpfc_sink
`default_nettype wire

// ---- tb/tb_color_pixel_format_convert.sv ----
// self-checking bench for the pixel format converter
// assumes cpfc_pkg, cpfc_top, cpfc_sink and the port checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_color_pixel_format_convert
    import cpfc_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  av_address = 4'h0;
    logic        av_read = 1'b0;
    logic        av_write = 1'b0;
    logic [31:0] av_writedata = 32'h0000_0000;
    logic [3:0]  av_byteenable = 4'h0;
    logic [31:0] av_readdata;
    logic        av_waitrequest;
    logic        in_valid = 1'b0;
    logic [11:0] in_data = 12'h000;
    logic        in_sof = 1'b0;
    logic        in_eol = 1'b0;
    logic        in_ready;
    logic        out_valid;
    logic [15:0] out_data;
    logic        out_ready;
    logic        stall = 1'b0;
    logic        full_seen = 1'b0;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #25 clk = ~clk;
    // short lines keep the run small
    cpfc_top #(.MAX_W(16), .DEPTH(16)) cpfc_top_inst (.clk(clk), .srst(srst),
        .av_address(av_address), .av_read(av_read), .av_write(av_write),
        .av_writedata(av_writedata), .av_byteenable(av_byteenable),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof), .in_eol(in_eol),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready));
    cpfc_sink cpfc_sink_inst (.clk(clk), .srst(srst), .stall(stall),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    // ----------------------------------------
    // common tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (in_valid && !in_ready && !srst) begin
            full_seen <= 1'b1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        av_address    <= a;
        av_write      <= wr;
        av_read       <= !wr;
        av_writedata  <= d;
        av_byteenable <= 4'hF;
        // hold the request until the edge that samples waitrequest low
        do begin
            @(posedge clk);
        end while (av_waitrequest !== 1'b0);
        rd = av_readdata;
        av_read  <= 1'b0;
        av_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic ctrl(input logic [31:0] v);
        logic [31:0] r;
        bus(1'b1, REG_CTRL, v, r);
        cpfc_sink_inst.q.delete();
    endtask : ctrl
    // in_valid stays up between samples so bursts run back to back
    task automatic px(input logic [11:0] d, input logic sof, input logic eol);
        in_valid <= 1'b1;
        in_data  <= d;
        in_sof   <= sof;
        in_eol   <= eol;
        do begin
            @(posedge clk);
        end while (in_ready !== 1'b1);
    endtask : px
    task automatic frame(input logic [11:0] v[8]);
        for (int i = 0; i < 8; i++) px(v[i], i == 0, i % 4 == 3);
        in_valid <= 1'b0;
        @(posedge clk);
    endtask : frame
    task automatic wait_words(input int n);
        while (cpfc_sink_inst.q.size() < n) @(posedge clk);
        repeat (8) @(posedge clk);
        chk("word_count", 32'(n), 32'(cpfc_sink_inst.q.size()));
    endtask : wait_words
    function automatic logic [7:0] cv(input int kr, kg, kb, ofs, r, g, b);
        int s;
        s = ((kr * r + kg * g + kb * b + 128) >>> 8) + ofs;
        return (s < 0) ? 8'h00 : (s > 255) ? 8'hFF : 8'(s);
    endfunction : cv
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        bus(1'b0, REG_CTRL, 32'h0000_0000, r);
        chk("ctrl_reset", 32'(CTRL_RST), r);
        bus(1'b0, REG_WB, 32'h0000_0000, r);
        chk("wb_reset", 32'(WB_RST), r);
        bus(1'b0, REG_SAT, 32'h0000_0000, r);
        chk("sat_reset", 32'(SAT_RST), r);
        bus(1'b1, 4'h1, 32'hFFFF_FFFF, r);
        bus(1'b0, 4'h1, 32'h0000_0000, r);
        chk("unmapped", 32'h0000_0000, r);
        bus(1'b1, REG_CTRL, 32'hFFFF_FFFF, r);
        bus(1'b0, REG_CTRL, 32'h0000_0000, r);
        chk("ctrl_width", 32'h0000_007F, r);
        $display("test regs done");
    endtask : t_regs
    task automatic t_raw8();
        logic [11:0] v[8];
        logic [31:0] r;
        for (int i = 0; i < 8; i++) v[i] = 12'h0A9 + 12'(i * 291);
        ctrl(32'(FMT_RAW8));
        frame(v);
        wait_words(8);
        for (int i = 0; i < 8; i++) chk("raw8", {24'h0, v[i][11:4]}, {16'h0, cpfc_sink_inst.q[i]});
        // eight words made since reset, fifo drained
        bus(1'b0, REG_STATUS, 32'h0000_0000, r);
        chk("status", 32'h0000_0008, r);
        $display("test raw8 done");
    endtask : t_raw8
    task automatic t_color(input logic [2:0] f, input int r, input int g, input int b);
        logic [11:0] v[8];
        logic [15:0] wd;
        logic [7:0]  y, u, w, lu, ch;
        y = cv(K_YR, K_YG, K_YB, 0, r, g, b);
        u = cv(K_UR, K_UG, K_UB, C_OFS, r, g, b);
        w = cv(K_VR, K_VG, K_VB, C_OFS, r, g, b);
        // blue-green phase: row 0 is B G B G, row 1 is G R G R
        v = '{{8'(b), 4'h9}, {8'(g), 4'h9}, {8'(b), 4'h9}, {8'(g), 4'h9},
              {8'(g), 4'h9}, {8'(r), 4'h9}, {8'(g), 4'h9}, {8'(r), 4'h9}};
        ctrl(32'(f));
        frame(v);
        wait_words(8);
        // column 0 lacks a left neighbour, so only columns 1..3 of row 1 are judged
        for (int c = 5; c < 8; c++) begin
            wd = cpfc_sink_inst.q[c];
            lu = (f == FMT_YUV_YU) ? wd[7:0] : wd[15:8];
            ch = (f == FMT_YUV_YU) ? wd[15:8] : wd[7:0];
            if (f == FMT_MONO8) begin
                chk("mono_word", {24'h0, y}, {16'h0, wd});
            end else begin
                chk("luma", {24'h0, y}, {24'h0, lu});
                if (c > 5) chk("chroma", {24'h0, (c == 6) ? u : w}, {24'h0, ch});
            end
        end
        $display("test colour format %0d done", f);
    endtask : t_color
    task automatic t_fifo();
        ctrl(32'(FMT_RAW12));
        stall <= 1'b1;
        fork
            for (int i = 0; i < 32; i++) px(12'h800 + 12'(i * 37), i == 0, i % 4 == 3);
            begin
                repeat (60) @(posedge clk);
                stall <= 1'b0;
            end
        join
        in_valid <= 1'b0;
        @(posedge clk);
        chk("ready_dropped", 32'h0000_0001, {31'h0, full_seen});
        wait_words(32);
        for (int i = 0; i < 32; i++) chk("raw12", {20'h0, 12'h800 + 12'(i * 37)}, {16'h0, cpfc_sink_inst.q[i]});
        $display("test fifo done");
    endtask : t_fifo
    // complementary path last: its unpaired samples leave the checker's count high
    task automatic t_comp();
        logic [11:0] v[8];
        for (int i = 0; i < 8; i++) v[i] = 12'h300 + 12'(i * 64);
        ctrl(32'h0000_007C);
        frame(v);
        frame(v);
        frame(v);
        wait_words(4 * 3);
        // first frame only warms the line memory and chroma state; the later two must agree
        for (int i = 0; i < 4; i++) begin
            chk("field_same", {16'h0, cpfc_sink_inst.q[i + 4]}, {16'h0, cpfc_sink_inst.q[i + 8]});
            chk("comp_mono", 32'h0000_0000, {24'h0, cpfc_sink_inst.q[i + 4][15:8]});
        end
        $display("test complementary done");
    endtask : t_comp
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_raw8();
        t_color(FMT_MONO8, 200, 40, 90);
        t_color(FMT_YUV_UY, 255, 0, 0);
        t_color(FMT_YUV_YU, 0, 0, 255);
        t_fifo();
        t_comp();
        final_report();
    end
endmodule : tb_color_pixel_format_convert
bind cpfc_top cpfc_top_assertions cpfc_top_assertions_inst (.clk(clk), .srst(srst),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_byteenable(av_byteenable),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof), .in_eol(in_eol),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready));
`default_nettype wire
